// file: bench/mdd_core_model.sv
// core-side model: issues internal, external and program accesses
// assumes the bench calls its tasks from a single process
`timescale 1ns/10ps
module mdd_core_model (
  input wire logic clk_sys,
  output logic id_valid,
  output logic [7:0] id_addr,
  output logic id_indirect,
  output logic id_bit,
  output logic [6:0] id_bit_index,
  output logic [1:0] bank_sel,
  output logic [7:0] page_sel,
  output logic xd_valid,
  output logic [15:0] xd_addr,
  output logic [1:0] map_mode,
  output logic mux_mode,
  output logic pm_valid,
  output logic [16:0] pm_addr,
  output logic small_variant,
  output logic erase_req
);
  // -------------------------------------------------------------
  // access tasks, launched just after a rising edge
  // -------------------------------------------------------------
  initial begin
    {id_valid, id_addr, id_indirect, id_bit, id_bit_index, bank_sel, page_sel} = '0;
    {xd_valid, xd_addr, map_mode, mux_mode, pm_valid, pm_addr, small_variant, erase_req} = '0;
  end
  // idle scrambles the internal address so a stale value cannot pass for a live one
  task automatic idle();
    @(posedge clk_sys);
    id_valid <= 1'b0;
    xd_valid <= 1'b0;
    pm_valid <= 1'b0;
    id_addr <= ~id_addr;
    #1;
  endtask
  task automatic id_acc(input logic [7:0] a, input logic ind, input logic bt,
                        input logic [6:0] bi, input logic [7:0] pg);
    @(posedge clk_sys);
    id_valid <= 1'b1;
    id_addr <= a;
    id_indirect <= ind;
    id_bit <= bt;
    id_bit_index <= bi;
    page_sel <= pg;
    bank_sel <= a[4:3];
    #1;
  endtask
  task automatic xd_acc(input logic [15:0] a, input logic [1:0] m);
    @(posedge clk_sys);
    xd_valid <= 1'b1;
    xd_addr <= a;
    map_mode <= m;
    #1;
  endtask
  // port mode only moves while no external access is live
  task automatic mux_set(input logic m);
    @(posedge clk_sys);
    xd_valid <= 1'b0;
    mux_mode <= m;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // a mode change under a live access must wait for the bus to go quiet
  task automatic mux_busy(input logic [15:0] a, input logic m);
    @(posedge clk_sys);
    xd_valid <= 1'b1;
    xd_addr <= a;
    mux_mode <= m;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic pm_acc(input logic [16:0] a, input logic er, input logic sv);
    @(posedge clk_sys);
    pm_valid <= 1'b1;
    pm_addr <= a;
    small_variant <= sv;
    erase_req <= er;
    if (er) begin
      @(posedge clk_sys);
      erase_req <= 1'b0;
    end
    #1;
  endtask
endmodule

// file: bench/mdd_top_tb_top.sv
// self-checking bench for the memory address decoder
// assumes the core model drives every decoder input except clk_sys and rst
`timescale 1ns/10ps
module mdd_top_tb_top
  import mdd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic id_valid, id_indirect, id_bit, xd_valid, mux_mode, pm_valid, small_variant, erase_req;
  logic ram_sel, special_function_space_sel, onchip_sel, external_memory_port_sel;
  logic external_memory_port_muxed, pm_fault, erase_ok;
  logic [1:0] bank_sel, map_mode, id_target, pm_region;
  logic [2:0] ram_bit, bank_seen_q;
  logic [6:0] id_bit_index;
  logic [7:0] id_addr, page_sel, ram_addr, erase_sector;
  logic [11:0] onchip_addr;
  logic [15:0] xd_addr, special_function_space_addr, external_memory_port_addr;
  logic [16:0] pm_addr;
  int n_mismatch = 0;
  int check_count = 0;
  always #50 clk_sys = ~clk_sys;
  mdd_core_model i_core (.clk_sys, .id_valid, .id_addr, .id_indirect, .id_bit, .id_bit_index,
    .bank_sel, .page_sel, .xd_valid, .xd_addr, .map_mode, .mux_mode, .pm_valid, .pm_addr,
    .small_variant, .erase_req);
  mdd_top i_dut (.clk_sys, .rst, .id_valid, .id_addr, .id_indirect, .id_bit, .id_bit_index,
    .bank_sel, .page_sel, .xd_valid, .xd_addr, .map_mode, .mux_mode, .pm_valid, .pm_addr,
    .small_variant, .erase_req, .id_target, .ram_addr, .ram_bit, .ram_sel,
    .special_function_space_sel, .special_function_space_addr, .onchip_sel, .onchip_addr,
    .external_memory_port_sel, .external_memory_port_muxed, .external_memory_port_addr,
    .pm_region, .pm_fault, .erase_ok, .erase_sector, .bank_seen_q);
  // -------------------------------------------------------------
  // compare and verdict
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_idata();
    i_core.id_acc(8'h90, 1'b0, 1'b0, 7'h00, 8'hff);
    chk({special_function_space_sel, ram_sel, id_target}, {2'b10, MDD_T_SPECIAL});
    chk(special_function_space_addr, 16'hff90);
    i_core.id_acc(8'h90, 1'b1, 1'b0, 7'h00, 8'h00);
    chk({id_target, ram_sel, ram_addr}, {MDD_T_UPPER_RAM, 9'h190});
    i_core.id_acc(8'hff, 1'b0, 1'b0, 7'h00, 8'h00);
    chk(special_function_space_addr, 16'h00ff);
    for (int m = 0; m < 2; m++) begin
      i_core.id_acc(8'h7f, m[0], 1'b0, 7'h00, 8'h12);
      chk({id_target, ram_sel, ram_addr}, {MDD_T_LOW_RAM, 9'h17f});
    end
    i_core.id_acc(8'h00, 1'b0, 1'b1, 7'h7f, 8'h00);
    chk({ram_addr, ram_bit}, {8'h2f, 3'h7});
    i_core.id_acc(8'h00, 1'b1, 1'b1, 7'h09, 8'h00);
    chk({ram_addr, ram_bit}, {8'h21, 3'h1});
    i_core.id_acc(8'h1f, 1'b0, 1'b0, 7'h00, 8'h00);
    i_core.idle();
    chk(bank_seen_q, 3'b111);
    chk({ram_sel, special_function_space_sel, id_target}, {2'b00, MDD_T_NONE});
    i_core.id_acc(8'h08, 1'b1, 1'b0, 7'h00, 8'h00);
    i_core.idle();
    chk(bank_seen_q, 3'b101);
  endtask
  // codes 0..3 against both sides of the 4 kB split point
  task automatic t_xdata();
    logic [15:0] al [3] = '{16'h0fff, 16'h1000, 16'hf123};
    logic on;
    for (int m = 0; m < 4; m++) begin
      foreach (al[i]) begin
        i_core.xd_acc(al[i], m[1:0]);
        on = (m == 0) || (m >= 2 && al[i] < 16'h1000);
        chk({onchip_sel, external_memory_port_sel}, {on, !on});
        if (on) chk(onchip_addr, al[i][11:0]);
        else chk(external_memory_port_addr, al[i]);
      end
    end
    i_core.mux_set(1'b1);
    chk(external_memory_port_muxed, 1'b1);
    i_core.mux_busy(16'h2000, 1'b0);
    chk(external_memory_port_muxed, 1'b1);
    i_core.mux_set(1'b0);
    chk(external_memory_port_muxed, 1'b0);
  endtask
  task automatic pm_case(input logic sv, input logic [16:0] a, input logic [1:0] r, input logic f);
    i_core.pm_acc(a, 1'b0, sv);
    chk({pm_region, pm_fault}, {r, f});
  endtask
  task automatic er_case(input logic [16:0] a, input logic ok, input logic [7:0] sec);
    i_core.pm_acc(a, 1'b1, 1'b0);
    chk({erase_ok, erase_sector}, {ok, sec});
  endtask
  task automatic t_prog();
    pm_case(1'b0, 17'h0fdff, MDD_P_USER, 1'b0);
    pm_case(1'b0, 17'h0fe00, MDD_P_RSVD, 1'b0);
    pm_case(1'b0, 17'h0ffff, MDD_P_RSVD, 1'b0);
    pm_case(1'b0, 17'h10000, MDD_P_EXTRA, 1'b0);
    pm_case(1'b0, 17'h1007f, MDD_P_EXTRA, 1'b0);
    pm_case(1'b0, 17'h10080, MDD_P_NONE, 1'b1);
    pm_case(1'b1, 17'h07fff, MDD_P_USER, 1'b0);
    pm_case(1'b1, 17'h08000, MDD_P_NONE, 1'b1);
    pm_case(1'b1, 17'h0fe00, MDD_P_NONE, 1'b1);
    pm_case(1'b1, 17'h10000, MDD_P_EXTRA, 1'b0);
    er_case(17'h00200, 1'b1, 8'h01);
    er_case(17'h005ff, 1'b1, 8'h02);
    er_case(17'h0fe00, 1'b0, 8'h02);
    er_case(17'h10000, 1'b1, 8'h80);
    er_case(17'h10080, 1'b0, 8'h80);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    chk({erase_ok, erase_sector, bank_seen_q, external_memory_port_muxed}, 32'h0);
    rst <= 1'b0;
    t_idata();
    t_xdata();
    t_prog();
    test_done();
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule

// file: core/mdd_pkg.sv
// package for the data and program memory address decoder
// assumes one system clock domain; no software-visible registers
package mdd_pkg;
  // ---------------------------------------------------------------
  // internal data space
  // ---------------------------------------------------------------
  localparam logic [7:0] MDD_UPPER_BASE = 8'h80;
  localparam logic [7:0] MDD_BANK_END = 8'h1f;
  localparam logic [7:0] MDD_BIT_BASE = 8'h20;
  localparam logic [7:0] MDD_BIT_END = 8'h2f;
  localparam int MDD_BANK_SHIFT = 3;
  // ---------------------------------------------------------------
  // external data space
  // ---------------------------------------------------------------
  localparam logic [15:0] MDD_ONCHIP_SIZE = 16'h1000;
  localparam int MDD_ONCHIP_AW = 12;
  // ---------------------------------------------------------------
  // program space
  // ---------------------------------------------------------------
  localparam logic [16:0] MDD_PROG_LARGE = 17'h10000;
  localparam logic [16:0] MDD_PROG_SMALL = 17'h08000;
  localparam logic [16:0] MDD_RSVD_LO = 17'h0fe00;
  localparam logic [16:0] MDD_RSVD_HI = 17'h0ffff;
  localparam logic [16:0] MDD_EXTRA_LO = 17'h10000;
  localparam logic [16:0] MDD_EXTRA_HI = 17'h1007f;
  localparam int MDD_SECTOR_SHIFT = 9;

  typedef enum logic [1:0] {MDD_MAP_ONCHIP, MDD_MAP_EXTERN, MDD_MAP_SPLIT,
                            MDD_MAP_SPLIT_ALT} mdd_map_t;
  typedef enum logic [1:0] {MDD_T_LOW_RAM, MDD_T_UPPER_RAM, MDD_T_SPECIAL,
                            MDD_T_NONE} mdd_idata_t;
  typedef enum logic [1:0] {MDD_P_NONE, MDD_P_USER, MDD_P_RSVD,
                            MDD_P_EXTRA} mdd_prog_t;
endpackage

// file: core/mdd_prog_map.sv
// program flash decode: user space, reserved top sector, extra sector
// assumes the variant strap is constant while running
`timescale 1ns/10ps
module mdd_prog_map
  import mdd_pkg::*;
(
  input wire logic [16:0] addr,
  input wire logic small_variant,
  output logic [1:0] region,
  output logic [7:0] sector
);
  always_comb begin
    sector = addr[16:MDD_SECTOR_SHIFT]; // RL11
    if (addr >= MDD_EXTRA_LO && addr <= MDD_EXTRA_HI) begin
      region = MDD_P_EXTRA; // RL13
    end else if (small_variant) begin
      region = (addr < MDD_PROG_SMALL) ? MDD_P_USER : MDD_P_NONE; // RL10
    end else if (addr >= MDD_RSVD_LO && addr <= MDD_RSVD_HI) begin
      region = MDD_P_RSVD; // RL12
    end else begin
      region = (addr < MDD_PROG_LARGE) ? MDD_P_USER : MDD_P_NONE; // RL10
    end
  end
endmodule

// file: core/mdd_top.sv
// data and program memory address decoder, top level
// assumes core-side requests are synchronous to clk_sys
//
// How it works
// [RL1] indirect upper half goes to RAM
// [RL2] direct upper half goes to special space
// [RL3] special space paged, up to 256 pages
// [RL4] lower half same storage both modes
// [RL5] first 32 bytes: four register banks
// [RL6] next 16 bytes byte and bit access
// [RL7] on-chip block aliases every 4 kB
// [RL8] map modes: on-chip, external, split
// [RL9] external port muxed or separate lines
// [RL10] program size 64 kB or 32 kB
// [RL11] flash erased in 512-byte sectors
// [RL12] 0xfe00-0xffff reserved on large parts
// [RL13] extra 128-byte sector at 0x10000
// [RL14] target resolved in the same cycle
`timescale 1ns/10ps
module mdd_top
  import mdd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic id_valid,
  input wire logic [7:0] id_addr,
  input wire logic id_indirect,
  input wire logic id_bit,
  input wire logic [6:0] id_bit_index,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] page_sel,
  input wire logic xd_valid,
  input wire logic [15:0] xd_addr,
  input wire logic [1:0] map_mode,
  input wire logic mux_mode,
  input wire logic pm_valid,
  input wire logic [16:0] pm_addr,
  input wire logic small_variant,
  input wire logic erase_req,
  output logic [1:0] id_target,
  output logic [7:0] ram_addr,
  output logic [2:0] ram_bit,
  output logic ram_sel,
  output logic special_function_space_sel,
  output logic [15:0] special_function_space_addr,
  output logic onchip_sel,
  output logic [11:0] onchip_addr,
  output logic external_memory_port_sel,
  output logic external_memory_port_muxed,
  output logic [15:0] external_memory_port_addr,
  output logic [1:0] pm_region,
  output logic pm_fault,
  output logic erase_ok,
  output logic [7:0] erase_sector,
  output logic [2:0] bank_seen_q
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] erase_sector;
    logic erase_ok;
    logic muxed;
    logic [2:0] bank_seen;
  } mdd_state_t;

  mdd_state_t st_q, st_d;
  logic xd_onchip;
  logic [1:0] pm_reg;
  logic [7:0] pm_sector;

  // ---------------------------------------------------------------
  // sub-decoders
  // ---------------------------------------------------------------
  mdd_xdata_map u_xdata (
    .addr(xd_addr),
    .map_mode(map_mode),
    .to_onchip(xd_onchip),
    .onchip_addr(onchip_addr)
  );

  mdd_prog_map u_prog (
    .addr(pm_addr),
    .small_variant(small_variant),
    .region(pm_reg),
    .sector(pm_sector)
  );

  // ---------------------------------------------------------------
  // internal data decode, purely combinational
  // ---------------------------------------------------------------
  always_comb begin
    id_target = MDD_T_NONE;
    ram_addr = id_addr;
    ram_bit = 3'h0;
    special_function_space_addr = {page_sel, id_addr}; // RL3
    if (id_valid) begin
      if (id_bit) begin
        // bit space: low half maps into the 16 bytes after the banks
        ram_bit = id_bit_index[2:0];
        ram_addr = MDD_BIT_BASE + {4'h0, id_bit_index[6:3]}; // RL6
        id_target = MDD_T_LOW_RAM; // RL6
      end else if (id_addr < MDD_UPPER_BASE) begin
        id_target = MDD_T_LOW_RAM; // RL4
        if (id_addr <= MDD_BANK_END && !id_indirect) begin
          ram_addr = id_addr; // RL5
        end
      end else if (id_indirect) begin
        id_target = MDD_T_UPPER_RAM; // RL1
      end else begin
        id_target = MDD_T_SPECIAL; // RL2
      end
    end
  end

  assign ram_sel = (id_target == MDD_T_LOW_RAM) || (id_target == MDD_T_UPPER_RAM); // RL14
  assign special_function_space_sel = id_target == MDD_T_SPECIAL; // RL14

  // ---------------------------------------------------------------
  // external data, program and bank tracking outputs
  // ---------------------------------------------------------------
  assign onchip_sel = xd_valid && xd_onchip; // RL8
  assign external_memory_port_sel = xd_valid && !xd_onchip; // RL8
  assign external_memory_port_addr = xd_addr;
  // mode is registered so the port never changes wiring mid-access
  assign external_memory_port_muxed = st_q.muxed; // RL9
  assign pm_region = pm_valid ? pm_reg : MDD_P_NONE; // RL14
  assign pm_fault = pm_valid && (pm_reg == MDD_P_NONE); // RL10
  assign erase_ok = st_q.erase_ok;
  assign erase_sector = st_q.erase_sector;
  assign bank_seen_q = st_q.bank_seen;

  // ---------------------------------------------------------------
  // registered state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.erase_ok = 1'b0;
    if (!xd_valid) begin
      st_d.muxed = mux_mode; // RL9
    end
    // reserved sector is never erasable by user code
    if (erase_req && (pm_reg == MDD_P_USER || pm_reg == MDD_P_EXTRA)) begin
      st_d.erase_ok = 1'b1; // RL11
      st_d.erase_sector = pm_sector; // RL11
    end
    if (id_valid && !id_bit && id_addr <= MDD_BANK_END) begin
      st_d.bank_seen = {1'b1, id_addr[4:MDD_BANK_SHIFT]}; // RL5
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_upper_indirect_ram: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    (id_valid && !id_bit && id_addr >= MDD_UPPER_BASE && id_indirect) |-> ram_sel)
    else $error("indirect upper access not sent to ram");
  a_upper_direct_sfs: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    (id_valid && !id_bit && id_addr >= MDD_UPPER_BASE && !id_indirect)
    |-> special_function_space_sel && !ram_sel)
    else $error("direct upper access not sent to special space");
  a_page_steer: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    special_function_space_sel |-> special_function_space_addr[15:8] == page_sel)
    else $error("special space page wrong");
  a_lower_both: assert property (@(posedge clk_sys) disable iff (rst) // RL4
    (id_valid && !id_bit && id_addr < MDD_UPPER_BASE) |-> ram_sel && ram_addr == id_addr)
    else $error("lower half not same storage");
  a_bank_track: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    (id_valid && !id_bit && id_addr <= MDD_BANK_END)
    |=> bank_seen_q[2] && 8'(bank_seen_q[1:0]) == ($past(id_addr) >> MDD_BANK_SHIFT))
    else $error("bank tracking wrong");
  a_bit_region: assert property (@(posedge clk_sys) disable iff (rst) // RL6
    (id_valid && id_bit) |-> ram_addr >= MDD_BIT_BASE && ram_addr <= MDD_BIT_END)
    else $error("bit access outside bit region");
  a_alias_4k: assert property (@(posedge clk_sys) disable iff (rst) // RL7
    (xd_valid && map_mode == 2'h0) |-> onchip_sel && onchip_addr == xd_addr[11:0])
    else $error("on-chip alias wrong");
  a_split_mode: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    (xd_valid && map_mode == 2'h2) |-> onchip_sel == (xd_addr < MDD_ONCHIP_SIZE))
    else $error("split mode wrong");
  a_rsvd_top: assert property (@(posedge clk_sys) disable iff (rst) // RL12
    (pm_valid && !small_variant && pm_addr >= MDD_RSVD_LO && pm_addr <= MDD_RSVD_HI)
    |-> pm_region == MDD_P_RSVD)
    else $error("reserved range not flagged");
  a_extra_sector: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    (pm_valid && pm_addr >= MDD_EXTRA_LO && pm_addr <= MDD_EXTRA_HI) |-> pm_region == MDD_P_EXTRA)
    else $error("extra sector not decoded");
  a_small_limit: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    (pm_valid && small_variant && pm_addr >= MDD_PROG_SMALL && pm_addr < MDD_EXTRA_LO)
    |-> pm_fault)
    else $error("small variant range not enforced");
  a_erase_pulse: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    (erase_req && pm_reg == MDD_P_RSVD) |=> !erase_ok)
    else $error("reserved sector erase accepted");

  // ---------------------------------------------------------------
  // checks: internal data space
  // ---------------------------------------------------------------
  a_upper_not_sfs: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    (id_valid && !id_bit && id_addr >= MDD_UPPER_BASE && id_indirect)
    |-> !special_function_space_sel && id_target == MDD_T_UPPER_RAM && ram_addr == id_addr)
    else $error("indirect upper access target wrong");
  a_page_low_byte: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    special_function_space_sel
    |-> special_function_space_addr[7:0] == id_addr)
    else $error("special space offset wrong");
  a_sel_exclusive: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    1'b1
    |-> !(ram_sel && special_function_space_sel))
    else $error("ram and special space both selected");
  a_id_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    !id_valid
    |-> !ram_sel && !special_function_space_sel && id_target == MDD_T_NONE)
    else $error("internal select without access");
  a_bank_window: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    (id_valid && !id_bit && id_addr <= MDD_BANK_END)
    |-> ram_sel && ram_addr == id_addr)
    else $error("register bank access misrouted");
  a_bank_hold: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    !(id_valid && !id_bit && id_addr <= MDD_BANK_END)
    |=> $stable(bank_seen_q))
    else $error("bank tracking moved without bank access");
  a_bit_number: assert property (@(posedge clk_sys) disable iff (rst) // RL6
    (id_valid && id_bit)
    |-> ram_bit == id_bit_index[2:0] && ram_addr[3:0] == id_bit_index[6:3])
    else $error("bit access byte or bit wrong");
  a_bit_target: assert property (@(posedge clk_sys) disable iff (rst) // RL6
    (id_valid && id_bit)
    |-> ram_sel && id_target == MDD_T_LOW_RAM)
    else $error("bit access not sent to ram");
  a_byte_bit_zero: assert property (@(posedge clk_sys) disable iff (rst) // RL6
    (id_valid && !id_bit)
    |-> ram_bit == 3'h0)
    else $error("byte access carries a bit number");

  // ---------------------------------------------------------------
  // checks: external data space
  // ---------------------------------------------------------------
  a_alias_addr: assert property (@(posedge clk_sys) disable iff (rst) // RL7
    onchip_sel
    |-> onchip_addr == xd_addr[11:0])
    else $error("on-chip offset wrong");
  a_onchip_high: assert property (@(posedge clk_sys) disable iff (rst) // RL7
    (xd_valid && map_mode == 2'h0 && xd_addr >= MDD_ONCHIP_SIZE)
    |-> onchip_sel && !external_memory_port_sel)
    else $error("high address not aliased on-chip");
  a_extern_only: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    (xd_valid && map_mode == 2'h1)
    |-> external_memory_port_sel && !onchip_sel)
    else $error("external-only mode reached on-chip block");
  a_spare_split: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    (xd_valid && map_mode == 2'h3)
    |-> onchip_sel == (xd_addr < MDD_ONCHIP_SIZE))
    else $error("spare map code not split");
  a_xd_one_target: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    xd_valid
    |-> onchip_sel != external_memory_port_sel)
    else $error("external data access has no single target");
  a_xd_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    !xd_valid
    |-> !onchip_sel && !external_memory_port_sel)
    else $error("external data select without access");
  a_ext_addr_pass: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    external_memory_port_sel
    |-> external_memory_port_addr == xd_addr)
    else $error("external port address wrong");
  a_mux_hold: assert property (@(posedge clk_sys) disable iff (rst) // RL9
    xd_valid
    |=> $stable(external_memory_port_muxed))
    else $error("port mode moved during access");
  a_mux_follow: assert property (@(posedge clk_sys) disable iff (rst) // RL9
    !xd_valid
    |=> external_memory_port_muxed == $past(mux_mode))
    else $error("port mode not taken while idle");

  // ---------------------------------------------------------------
  // checks: program space
  // ---------------------------------------------------------------
  a_small_user: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    (pm_valid && small_variant && pm_addr < MDD_PROG_SMALL)
    |-> pm_region == MDD_P_USER && !pm_fault)
    else $error("small variant user range refused");
  a_beyond_fault: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    (pm_valid && pm_addr > MDD_EXTRA_HI)
    |-> pm_fault && pm_region == MDD_P_NONE)
    else $error("address beyond program space accepted");
  a_pm_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    !pm_valid
    |-> pm_region == MDD_P_NONE && !pm_fault)
    else $error("program region shown without access");
  a_erase_accept: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    (erase_req && (pm_reg == MDD_P_USER || pm_reg == MDD_P_EXTRA))
    |=> erase_ok && 17'(erase_sector) == ($past(pm_addr) >> MDD_SECTOR_SHIFT))
    else $error("accepted erase not reported");
  a_erase_idle: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    !erase_req
    |=> !erase_ok)
    else $error("erase reported without request");
  a_small_no_rsvd: assert property (@(posedge clk_sys) disable iff (rst) // RL12
    (pm_valid && small_variant && pm_addr >= MDD_RSVD_LO && pm_addr <= MDD_RSVD_HI)
    |-> pm_region != MDD_P_RSVD)
    else $error("reserved range flagged on small variant");
endmodule

// file: core/mdd_xdata_map.sv
// external data space mapping: on-chip 4 kB block or external memory port
// assumes the mode input is stable for the duration of an access
`timescale 1ns/10ps
module mdd_xdata_map
  import mdd_pkg::*;
(
  input wire logic [15:0] addr,
  input wire logic [1:0] map_mode,
  output logic to_onchip,
  output logic [11:0] onchip_addr
);
  always_comb begin
    onchip_addr = addr[MDD_ONCHIP_AW-1:0]; // RL7
    unique case (mdd_map_t'(map_mode))
      MDD_MAP_ONCHIP: to_onchip = 1'b1; // RL7
      MDD_MAP_EXTERN: to_onchip = 1'b0; // RL8
      // the spare code behaves as split so no access is lost
      default: to_onchip = addr < MDD_ONCHIP_SIZE; // RL8
    endcase
  end
endmodule
